// ---- drive_status_pkg.sv ----
package drive_status_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam int MS_TIME_US = 1000;
	localparam int MS_CYCLES = CLK_HZ / 1_000_000 * MS_TIME_US;
	localparam logic [23:0] CLK_HZ_24 = 24'h989680;
	// Frequencies in 0.01 Hz, percentages in 0.1 %, voltages in 0.01 V
	localparam logic [19:0] ARRIVAL_WIDTH_RST = 20'h000FA;
	localparam logic [19:0] ARRIVAL_WIDTH_MAX = 20'h493E0;
	localparam logic [19:0] LEVEL_B_UPPER_RST = 20'h009C4;
	localparam logic [19:0] LEVEL_B_LOWER_RST = 20'h00960;
	localparam logic [9:0] ZERO_THR_RST = 10'h00A;
	localparam logic [9:0] ZERO_THR_MAX = 10'h3E8;
	localparam logic [9:0] PER_MILLE = 10'h3E8;
	localparam logic [19:0] FS_CUR = 20'h007D0;
	localparam logic [19:0] FS_TORQUE = 20'h00BB8;
	localparam logic [19:0] FS_VOLT = 20'h005DC;
	localparam logic [19:0] FS_AI = 20'h003E8;
	localparam logic [19:0] FS_RAW = 20'h0FFFF;
	localparam logic [8:0] RATE_MIN = 9'h001;
	localparam logic [8:0] RATE_MAX = 9'h1F4;
	localparam logic [8:0] RATE_RST = 9'h064;
	localparam logic [6:0] HZ_PER_RATE = 7'h64;
	localparam logic [16:0] FRAC_FULL = 17'h10000;
	localparam logic [16:0] FRAC_CENTRE = 17'h08000;
	localparam logic [5:0] FN_ARRIVAL = 6'h01;
	localparam logic [5:0] FN_LEVEL_A = 6'h03;
	localparam logic [5:0] FN_LEVEL_B = 6'h04;
	localparam logic [5:0] FN_ZERO = 6'h0A;
	localparam logic [5:0] FN_LAST = 6'h2C;
	localparam logic [4:0] SRC_NONE = 5'h00;
	localparam logic [4:0] SRC_LAST = 5'h13;
	typedef enum logic [1:0] {CM_NONE = 2'b00, CM_LOW_POS = 2'b01, CM_HIGH_POS = 2'b10} centre_t;
	typedef struct packed {
		logic [19:0] outFreq;
		logic [19:0] setFreq;
		logic [19:0] feedbackFreq;
		logic [19:0] motorSpeed;
		logic signed [15:0] driveCurrent;
		logic signed [15:0] motorCurrent;
		logic signed [15:0] outTorque;
		logic signed [15:0] torqueCurrent;
		logic signed [15:0] outVoltage;
		logic signed [15:0] ai1Volt;
		logic signed [15:0] ai2Volt;
		logic signed [15:0] outPower;
		logic signed [15:0] torqueLimElec;
		logic signed [15:0] torqueLimBrake;
		logic signed [15:0] torqueOffset;
		logic signed [15:0] torqueRef;
		logic [15:0] hostExpansion;
		logic [15:0] busCardPct;
	} drive_qty_t;
	typedef struct packed {
		logic [19:0] maxOutputFreq;
		logic [19:0] arrivalWidthSetting;
		logic [19:0] levelAUpper;
		logic [19:0] levelALower;
		logic [19:0] levelBUpper;
		logic [19:0] levelBLower;
		logic [4:0] pulseSourceSelect;
		logic [8:0] pulseMaxRate;
		centre_t centreModeSelect;
		logic [9:0] zeroSpeedThreshold;
		logic collectorOnePulse;
		logic vfMode;
		logic [2:0][5:0] termFunc;
		logic [2:0] termNegative;
		logic [15:0] relayDelayMs;
	} setting_t;
endpackage

// ---- serial_ratio_divider.sv ----
`timescale 1ns/1ps
module serial_ratio_divider (
	input wire logic mclk,
	input wire logic reset,
	input wire logic start,
	input wire logic [35:0] dividend,
	input wire logic [19:0] divisor,
	output logic [35:0] quotient,
	output logic done
);
	logic busy_ff, nxt_busy;
	logic done_ff, nxt_done;
	logic [5:0] count_ff, nxt_count;
	logic [20:0] rem_ff, nxt_rem;
	logic [35:0] work_ff, nxt_work;
	logic [19:0] divisor_ff, nxt_divisor;
	logic [20:0] trial;
	logic fits;

	// Restoring division, one quotient bit per cycle; a zero divisor yields all ones
	// Divisor is held from start so a changing source cannot corrupt a division
	always_comb
	begin
		nxt_busy = busy_ff;
		nxt_done = 1'b0;
		nxt_count = count_ff;
		nxt_rem = rem_ff;
		nxt_work = work_ff;
		nxt_divisor = divisor_ff;
		trial = {rem_ff[19:0], work_ff[35]};
		fits = trial >= {1'b0, divisor_ff};
		if (busy_ff)
		begin
			nxt_rem = fits ? trial - {1'b0, divisor_ff} : trial;
			nxt_work = {work_ff[34:0], fits};
			nxt_count = count_ff - 6'h01;
			if (count_ff == 6'h00)
			begin
				nxt_busy = 1'b0;
				nxt_done = 1'b1;
			end
		end
		else if (start)
		begin
			nxt_busy = 1'b1;
			nxt_count = 6'h23;
			nxt_rem = 21'h000000;
			nxt_work = dividend;
			nxt_divisor = divisor;
		end
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			count_ff <= 6'h00;
			rem_ff <= 21'h000000;
			work_ff <= 36'h000000000;
			divisor_ff <= 20'h00000;
		end
		else
		begin
			busy_ff <= nxt_busy;
			done_ff <= nxt_done;
			count_ff <= nxt_count;
			rem_ff <= nxt_rem;
			work_ff <= nxt_work;
			divisor_ff <= nxt_divisor;
		end
	end

	assign quotient = work_ff;
	assign done = done_ff;
endmodule

// ---- drive_status_pulse_output.sv ----
`timescale 1ns/1ps
module drive_status_pulse_output #(
	parameter int MS_CYCLES_P = drive_status_pkg::MS_CYCLES
) (
	input wire logic mclk,
	input wire logic reset,
	input wire drive_status_pkg::drive_qty_t qty,
	input wire drive_status_pkg::setting_t cfg,
	input wire logic [44:0] funcIn,
	output logic collectorOutOne,
	output logic collectorOutTwo,
	output logic relayOutOne,
	output logic freqArrivalFlag,
	output logic freqLevelDetectA,
	output logic freqLevelDetectB,
	output logic zeroSpeedFlag,
	output logic [15:0] pulseFreqHz
);
	import drive_status_pkg::*;

	typedef enum logic [1:0] {PS_START = 2'b00, PS_WAIT = 2'b01, PS_SCALE = 2'b10} pulse_state_t;

	// Selected source as signed value and its full-scale figure
	function automatic logic [40:0] pickSource(input logic [4:0] sel, input drive_qty_t q,
		input logic [19:0] fmax);
		logic signed [20:0] v;
		logic [19:0] fs;
		v = 21'sh000000;
		fs = FS_RAW;
		unique case (sel)
			5'h01: begin v = $signed({1'b0, q.outFreq}); fs = fmax; end
			5'h02: begin v = $signed({1'b0, q.setFreq}); fs = fmax; end
			5'h03: begin v = 21'(q.driveCurrent); fs = FS_CUR; end
			5'h04: begin v = 21'(q.motorCurrent); fs = FS_CUR; end
			5'h05: begin v = 21'(q.outTorque); fs = FS_TORQUE; end
			5'h06: begin v = 21'(q.torqueCurrent); fs = FS_TORQUE; end
			5'h07: begin v = $signed({1'b0, q.motorSpeed}); fs = fmax; end
			5'h08: begin v = 21'(q.outVoltage); fs = FS_VOLT; end
			5'h09: begin v = 21'(q.ai1Volt); fs = FS_AI; end
			5'h0A: begin v = 21'(q.ai2Volt); fs = FS_AI; end
			5'h0C: begin v = 21'(q.outPower); fs = FS_CUR; end
			5'h0D: begin v = 21'(q.torqueLimElec); fs = FS_TORQUE; end
			5'h0E: begin v = 21'(q.torqueLimBrake); fs = FS_TORQUE; end
			5'h0F: begin v = 21'(q.torqueOffset); fs = FS_TORQUE; end
			5'h10: begin v = 21'(q.torqueRef); fs = FS_TORQUE; end
			5'h11: begin v = $signed({5'h00, q.hostExpansion}); fs = FS_RAW; end
			5'h13: begin v = $signed({5'h00, q.busCardPct}); fs = FS_RAW; end
			default: begin v = 21'sh000000; fs = FS_RAW; end
		endcase
		return {v, fs};
	endfunction

	function automatic logic termState(input logic [5:0] code, input logic [44:0] flags);
		return (code <= FN_LAST) ? flags[code] : 1'b0;
	endfunction

	pulse_state_t pstate_ff, nxt_pstate;
	logic srcNeg_ff, nxt_srcNeg;
	logic [15:0] pulseHz_ff, nxt_pulseHz;
	logic [16:0] frac_ff, nxt_frac;
	logic [23:0] phase_ff, nxt_phase;
	logic wave_ff, nxt_wave;
	logic divStart;
	logic divDone;
	logic [35:0] divQuot;
	logic [40:0] picked;
	logic signed [20:0] srcVal;
	logic [19:0] srcFull;
	logic [19:0] srcMag;
	logic [16:0] ratio;
	logic signed [18:0] signedRatio;
	logic signed [18:0] centred;
	logic [8:0] rate;
	logic [33:0] product;
	logic [24:0] phaseSum;

	assign picked = pickSource(cfg.pulseSourceSelect, qty, cfg.maxOutputFreq);
	assign srcVal = $signed(picked[40:20]);
	assign srcFull = picked[19:0];
	assign srcMag = srcVal[20] ? 20'(-srcVal) : srcVal[19:0];
	assign ratio = (divQuot > 36'(FRAC_FULL)) ? FRAC_FULL : divQuot[16:0];
	assign signedRatio = srcNeg_ff ? -$signed({2'b00, ratio}) : $signed({2'b00, ratio});
	assign divStart = pstate_ff == PS_START;

	serial_ratio_divider i_serial_ratio_divider (
		.mclk(mclk),
		.reset(reset),
		.start(divStart),
		.dividend({srcMag, 16'h0000}),
		.divisor(srcFull),
		.quotient(divQuot),
		.done(divDone)
	);

	// Source sampling, normalising and centre-point placement
	always_comb
	begin
		nxt_pstate = pstate_ff;
		nxt_srcNeg = srcNeg_ff;
		nxt_frac = frac_ff;
		nxt_pulseHz = pulseHz_ff;
		centred = 19'sh00000;
		rate = cfg.pulseMaxRate < RATE_MIN ? RATE_MIN : cfg.pulseMaxRate;
		rate = rate > RATE_MAX ? RATE_MAX : rate;
		product = 34'(frac_ff) * 34'(rate) * 34'(HZ_PER_RATE);
		unique case (pstate_ff)
			PS_START:
			begin
				nxt_srcNeg = srcVal[20];
				nxt_pstate = PS_WAIT;
			end
			PS_WAIT:
			begin
				if (divDone)
				begin
					unique case (cfg.centreModeSelect)
						CM_LOW_POS: centred = $signed({2'b00, FRAC_CENTRE}) - (signedRatio >>> 1);
						CM_HIGH_POS: centred = $signed({2'b00, FRAC_CENTRE}) + (signedRatio >>> 1);
						default: centred = signedRatio;
					endcase
					if (centred < 0)
						nxt_frac = 17'h00000;
					else if (centred > $signed({2'b00, FRAC_FULL}))
						nxt_frac = FRAC_FULL;
					else
						nxt_frac = centred[16:0];
					if (cfg.pulseSourceSelect == SRC_NONE || cfg.pulseSourceSelect > SRC_LAST)
						nxt_frac = 17'h00000;
					nxt_pstate = PS_SCALE;
				end
			end
			PS_SCALE:
			begin
				nxt_pulseHz = product[31:16];
				nxt_pstate = PS_START;
			end
			default: nxt_pstate = PS_START;
		endcase
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			pstate_ff <= PS_START;
			srcNeg_ff <= 1'b0;
			frac_ff <= 17'h00000;
			pulseHz_ff <= 16'h0000;
		end
		else
		begin
			pstate_ff <= nxt_pstate;
			srcNeg_ff <= nxt_srcNeg;
			frac_ff <= nxt_frac;
			pulseHz_ff <= nxt_pulseHz;
		end
	end

	// Phase accumulator: two edges per period at the scaled rate
	always_comb
	begin
		phaseSum = {1'b0, phase_ff} + {8'h00, pulseHz_ff, 1'b0};
		nxt_phase = phaseSum[23:0];
		nxt_wave = wave_ff;
		if (phaseSum >= {1'b0, CLK_HZ_24})
		begin
			nxt_phase = 24'(phaseSum - {1'b0, CLK_HZ_24});
			nxt_wave = ~wave_ff;
		end
		if (!cfg.collectorOnePulse || pulseHz_ff == 16'h0000)
		begin
			nxt_phase = 24'h000000;
			nxt_wave = 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			phase_ff <= 24'h000000;
			wave_ff <= 1'b0;
		end
		else
		begin
			phase_ff <= nxt_phase;
			wave_ff <= nxt_wave;
		end
	end

	// Detectors
	logic arrival_ff, nxt_arrival;
	logic levelA_ff, nxt_levelA;
	logic levelB_ff, nxt_levelB;
	logic zero_ff, nxt_zero;
	logic [19:0] freqErr;
	logic [29:0] fbScaled;
	logic [29:0] thrScaled;

	always_comb
	begin
		freqErr = qty.outFreq >= qty.setFreq ? qty.outFreq - qty.setFreq
			: qty.setFreq - qty.outFreq;
		nxt_arrival = freqErr <= cfg.arrivalWidthSetting;
		nxt_levelA = levelA_ff;
		if (qty.outFreq > cfg.levelAUpper)
			nxt_levelA = 1'b1;
		else if (qty.outFreq < cfg.levelALower)
			nxt_levelA = 1'b0;
		nxt_levelB = levelB_ff;
		if (qty.outFreq > cfg.levelBUpper)
			nxt_levelB = 1'b1;
		else if (qty.outFreq < cfg.levelBLower)
			nxt_levelB = 1'b0;
		fbScaled = 30'(qty.feedbackFreq) * 30'(PER_MILLE);
		thrScaled = 30'(cfg.maxOutputFreq) * 30'(cfg.zeroSpeedThreshold);
		nxt_zero = cfg.vfMode ? qty.outFreq == 20'h00000 : fbScaled < thrScaled;
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			arrival_ff <= 1'b0;
			levelA_ff <= 1'b0;
			levelB_ff <= 1'b0;
			zero_ff <= 1'b0;
		end
		else
		begin
			arrival_ff <= nxt_arrival;
			levelA_ff <= nxt_levelA;
			levelB_ff <= nxt_levelB;
			zero_ff <= nxt_zero;
		end
	end

	// Terminal routing, polarity and relay delay
	logic [44:0] flags;
	logic [2:0] termLevel;
	logic [2:0] pin_ff, nxt_pin;
	logic [15:0] relayCnt_ff, nxt_relayCnt;
	logic [13:0] msDiv_ff, nxt_msDiv;
	logic msTick;

	always_comb
	begin
		flags = funcIn;
		flags[FN_ARRIVAL] = arrival_ff;
		flags[FN_LEVEL_A] = levelA_ff;
		flags[FN_LEVEL_B] = levelB_ff;
		flags[FN_ZERO] = zero_ff;
		for (int t = 0; t < 3; t++)
			termLevel[t] = termState(cfg.termFunc[t], flags) ^ cfg.termNegative[t];
		msTick = msDiv_ff == 14'(MS_CYCLES_P - 1);
		nxt_msDiv = msTick ? 14'h0000 : msDiv_ff + 14'h0001;
		nxt_pin = pin_ff;
		nxt_pin[0] = cfg.collectorOnePulse ? wave_ff : termLevel[0];
		nxt_pin[1] = termLevel[1];
		nxt_relayCnt = 16'h0000;
		if (termLevel[2] != pin_ff[2])
		begin
			if (relayCnt_ff >= cfg.relayDelayMs)
				nxt_pin[2] = termLevel[2];
			else
				nxt_relayCnt = msTick ? relayCnt_ff + 16'h0001 : relayCnt_ff;
		end
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			pin_ff <= 3'h0;
			relayCnt_ff <= 16'h0000;
			msDiv_ff <= 14'h0000;
		end
		else
		begin
			pin_ff <= nxt_pin;
			relayCnt_ff <= nxt_relayCnt;
			msDiv_ff <= nxt_msDiv;
		end
	end

	assign collectorOutOne = pin_ff[0];
	assign collectorOutTwo = pin_ff[1];
	assign relayOutOne = pin_ff[2];
	assign freqArrivalFlag = arrival_ff;
	assign freqLevelDetectA = levelA_ff;
	assign freqLevelDetectB = levelB_ff;
	assign zeroSpeedFlag = zero_ff;
	assign pulseFreqHz = pulseHz_ff;

	default clocking @(posedge mclk); endclocking
	default disable iff (reset);

	sequence ScaleDone;
		pstate_ff == PS_SCALE;
	endsequence

	AST_NEG_POLARITY: assert property (cfg.termNegative[1] && termState(cfg.termFunc[1], flags)
		|=> !collectorOutTwo)
		else $error("negative polarity terminal driven while active");
	AST_RELAY_DELAY: assert property ($changed(relayOutOne) |->
		$past(relayCnt_ff) >= $past(cfg.relayDelayMs))
		else $error("relay changed before its delay expired");
	AST_ARRIVAL: assert property ($stable(qty) && $stable(cfg) && freqErr <= cfg.arrivalWidthSetting
		|=> freqArrivalFlag)
		else $error("arrival flag missing inside window");
	AST_LEVEL_SET: assert property (qty.outFreq > cfg.levelBUpper |=> freqLevelDetectB)
		else $error("level detector not set above upper limit");
	AST_LEVEL_HOLD: assert property (freqLevelDetectA && qty.outFreq >= cfg.levelALower
		|=> freqLevelDetectA)
		else $error("level detector dropped above lower limit");
	AST_SRC_NONE: assert property (ScaleDone ##0 ($past(cfg.pulseSourceSelect) == SRC_NONE)
		|-> frac_ff == 17'h00000)
		else $error("no-function source produced pulses");
	AST_RATE_CLAMP: assert property (pulseFreqHz <= 16'(RATE_MAX) * 16'(HZ_PER_RATE))
		else $error("pulse rate above maximum");
	AST_CENTRE: assert property (ScaleDone ##0 (ratio == 17'h00000 && $stable(cfg)
		&& (cfg.centreModeSelect == CM_LOW_POS || cfg.centreModeSelect == CM_HIGH_POS)
		&& cfg.pulseSourceSelect != SRC_NONE && cfg.pulseSourceSelect <= SRC_LAST)
		|-> frac_ff == FRAC_CENTRE)
		else $error("zero value not placed at centre");
	AST_MODE0_POS: assert property (ScaleDone ##0 (cfg.centreModeSelect == CM_NONE && srcNeg_ff
		&& $stable(cfg)) |-> frac_ff == 17'h00000)
		else $error("negative value in mode without centre");
	AST_ZERO_VF: assert property (cfg.vfMode && qty.outFreq == 20'h00000 |=> zeroSpeedFlag)
		else $error("zero speed flag missing in V/F mode");
	AST_DIGITAL_Y: assert property (!cfg.collectorOnePulse ##1 !cfg.collectorOnePulse
		|-> collectorOutOne == $past(termLevel[0]))
		else $error("collector one not following its function in digital mode");
endmodule

// ---- ext_equipment_model.sv ----
`timescale 1ns/1ps
// Load on the collector output: counts rising edges of the pulse wave while enabled
module ext_equipment_model (
	input wire logic mclk,
	input wire logic countEn,
	input wire logic collectorPin,
	output int edgeCount
);
	logic lastPin;
	always_ff @(posedge mclk)
	begin
		lastPin <= collectorPin;
		if (!countEn)
			edgeCount <= 0;
		else if (collectorPin && !lastPin)
			edgeCount <= edgeCount + 1;
	end
endmodule

// ---- drive_status_pulse_output_tb.sv ----
`timescale 1ns/1ps
`define CHK(what, exp, got) \
	begin \
		nTests++; \
		if ((got) !== (exp)) \
		begin \
			errCount++; \
			$display("wrong value %s expected %0h seen %0h", what, exp, got); \
		end \
	end
module drive_status_pulse_output_tb;
	import drive_status_pkg::*;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	drive_qty_t qty;
	setting_t cfg;
	logic [44:0] funcIn = '0;
	logic collectorOutOne, collectorOutTwo, relayOutOne;
	logic freqArrivalFlag, freqLevelDetectA, freqLevelDetectB, zeroSpeedFlag;
	logic [15:0] pulseFreqHz;
	logic countEn = 1'b0;
	int edgeCount;
	int errCount = 0;
	int nTests = 0;
	int cycles = 0;
	logic [19:0] lvlFreq [6] = '{20'h003E8, 20'h003E9, 20'h009C5, 20'h00960, 20'h00384, 20'h00383};
	logic lvlA [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
	logic lvlB [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
	logic [4:0] pSrc [15] = '{5'h00, 5'h01, 5'h03, 5'h04, 5'h05, 5'h08, 5'h0B, 5'h0D, 5'h10, 5'h11,
		5'h13, 5'h03, 5'h03, 5'h11, 5'h13};
	logic [1:0] pMode [15] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
		2'h1, 2'h2, 2'h0, 2'h1};
	logic [15:0] pExp [15] = '{16'h0000, 16'h1388, 16'h1388, 16'h2710, 16'h1388, 16'h1388, 16'h0000,
		16'h2710, 16'h0000, 16'h2710, 16'h0000, 16'h09C4, 16'h1D4C, 16'hC350, 16'h1388};

	always #50 mclk = ~mclk;

	drive_status_pulse_output #(.MS_CYCLES_P(10)) i_drive_status_pulse_output (
		.mclk(mclk),
		.reset(reset),
		.qty(qty),
		.cfg(cfg),
		.funcIn(funcIn),
		.collectorOutOne(collectorOutOne),
		.collectorOutTwo(collectorOutTwo),
		.relayOutOne(relayOutOne),
		.freqArrivalFlag(freqArrivalFlag),
		.freqLevelDetectA(freqLevelDetectA),
		.freqLevelDetectB(freqLevelDetectB),
		.zeroSpeedFlag(zeroSpeedFlag),
		.pulseFreqHz(pulseFreqHz)
	);

	ext_equipment_model i_ext_equipment_model (
		.mclk(mclk),
		.countEn(countEn),
		.collectorPin(collectorOutOne),
		.edgeCount(edgeCount)
	);

	task automatic tick(input int n);
		repeat (n) @(negedge mclk);
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", nTests, errCount);
		if (errCount == 0 && nTests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Hang guard, well above the expected run of about 22000 cycles
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			errCount++;
			conclude();
		end
	end

	initial
	begin
		qty = '0;
		cfg = '0;
		cfg.maxOutputFreq = 20'h01388;
		cfg.arrivalWidthSetting = ARRIVAL_WIDTH_RST;
		cfg.levelAUpper = 20'h003E8;
		cfg.levelALower = 20'h00384;
		cfg.levelBUpper = LEVEL_B_UPPER_RST;
		cfg.levelBLower = LEVEL_B_LOWER_RST;
		cfg.pulseMaxRate = RATE_RST;
		cfg.zeroSpeedThreshold = ZERO_THR_RST;
		cfg.vfMode = 1'b1;
		cfg.termFunc[0] = FN_LEVEL_A;
		cfg.termFunc[1] = FN_LEVEL_B;
		cfg.termFunc[2] = FN_ARRIVAL;
		cfg.relayDelayMs = 16'h0003;
		qty.outFreq = 20'h003E8;
		tick(8);
		`CHK("relay in reset", 1'b0, relayOutOne)
		`CHK("pulse in reset", 16'h0000, pulseFreqHz)
		reset = 1'b0;
		tick(3);
		// Hysteresis walk through both detectors, terminals follow two cycles later
		for (int i = 0; i < 6; i++)
		begin
			qty.outFreq = lvlFreq[i];
			tick(3);
			`CHK("level a", lvlA[i], freqLevelDetectA)
			`CHK("level b", lvlB[i], freqLevelDetectB)
			`CHK("collector one digital", lvlA[i], collectorOutOne)
			`CHK("collector two", lvlB[i], collectorOutTwo)
		end
		cfg.termNegative = 3'b010;
		tick(3);
		`CHK("negative polarity", 1'b1, collectorOutTwo)
		qty.outFreq = 20'h009C5;
		tick(3);
		`CHK("negative polarity active", 1'b0, collectorOutTwo)
		cfg.termNegative = 3'b000;
		cfg.termFunc[1] = 6'h0F;
		funcIn[15] = 1'b1;
		tick(3);
		`CHK("external function", 1'b1, collectorOutTwo)
		cfg.termFunc[1] = 6'h32;
		tick(3);
		`CHK("code above range", 1'b0, collectorOutTwo)
		// Arrival at the inclusive edge of the width, relay follows after three ms ticks
		qty.outFreq = 20'h01388;
		qty.setFreq = 20'h01482;
		tick(2);
		`CHK("arrival inside", 1'b1, freqArrivalFlag)
		tick(16);
		`CHK("relay held", 1'b0, relayOutOne)
		tick(22);
		`CHK("relay after delay", 1'b1, relayOutOne)
		qty.setFreq = 20'h01483;
		tick(2);
		`CHK("arrival outside", 1'b0, freqArrivalFlag)
		tick(40);
		`CHK("relay released", 1'b0, relayOutOne)
		qty.outFreq = 20'h00000;
		tick(2);
		`CHK("zero in vf", 1'b1, zeroSpeedFlag)
		cfg.vfMode = 1'b0;
		qty.outFreq = 20'h01388;
		qty.feedbackFreq = 20'h00031;
		tick(2);
		`CHK("zero below threshold", 1'b1, zeroSpeedFlag)
		qty.feedbackFreq = 20'h00032;
		tick(2);
		`CHK("zero at threshold", 1'b0, zeroSpeedFlag)
		// Pulse sources, modes, clamps and the top rate
		cfg.collectorOnePulse = 1'b1;
		qty.outFreq = 20'h009C4;
		qty.driveCurrent = 16'sh03E8;
		qty.motorCurrent = 16'sh07D0;
		qty.outTorque = 16'sh05DC;
		qty.outVoltage = 16'sh02EE;
		qty.torqueLimElec = 16'sh0FA0;
		qty.torqueRef = -16'sh012C;
		qty.hostExpansion = 16'hFFFF;
		for (int i = 0; i < 15; i++)
		begin
			cfg.pulseSourceSelect = pSrc[i];
			cfg.centreModeSelect = centre_t'(pMode[i]);
			cfg.pulseMaxRate = (i == 13) ? RATE_MAX : RATE_RST;
			tick(100);
			`CHK("pulse rate", pExp[i], pulseFreqHz)
		end
		// Wave on the pin: 10 kHz over 2 ms gives twenty edges
		cfg.pulseSourceSelect = 5'h04;
		cfg.pulseMaxRate = RATE_RST;
		cfg.centreModeSelect = CM_NONE;
		tick(100);
		countEn = 1'b1;
		tick(20000);
		`CHK("wave edges", 1'b1, (edgeCount >= 19 && edgeCount <= 21))
		countEn = 1'b0;
		conclude();
	end
endmodule
